// file: rtl/mfc_pkg.sv
// Package: constants, types and register map of the manual flash command sequencer
package mfc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_HZ        = 40_000_000;
    localparam int          CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int          BEAT_NS       = 200;
    localparam int          BEAT_CYC      = BEAT_NS / CLK_PERIOD_NS;
    localparam logic [2:0]  BEAT_LAST     = 3'(BEAT_CYC - 1);
    localparam logic [2:0]  EDGE_AT       = 3'(BEAT_CYC / 2);
    localparam logic [2:0]  SAMPLE_AT     = 3'(BEAT_CYC - 1);

    // ------------------------------------------------------------
    // Register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_ADDR      = 8'h04;
    localparam logic [7:0]  REG_STAT      = 8'h08;
    localparam logic [7:0]  REG_RDATA     = 8'h0c;
    localparam logic [7:0]  REG_IDLE      = 8'h10;
    localparam logic [7:0]  REG_OPT       = 8'h14;

    // Control fields
    localparam int          CTRL_START    = 0;
    localparam int          CTRL_CMD_SEL  = 1;
    localparam int          CTRL_OCTAL    = 2;
    localparam int          CTRL_OPT_EN   = 3;
    localparam int          CTRL_OCMD_EN  = 4;
    // Status fields
    localparam int          STAT_BUSY     = 0;
    localparam int          STAT_WEL_SENT = 1;
    // Idle register fields
    localparam int          IDLE_LVL_LSB  = 0;
    localparam int          IDLE_FLT_LSB  = 8;

    // ------------------------------------------------------------
    // Reset values and idle selection codes
    // ------------------------------------------------------------
    localparam logic [7:0]  IDLE_LVL_RST  = 8'h55;
    localparam logic [7:0]  IDLE_FLT_RST  = 8'hff;
    localparam logic [31:0] OPT_RST       = 32'h0000_0000;
    localparam logic [1:0]  SEL_FLOAT     = 2'b11;
    localparam logic [1:0]  SEL_ONE       = 2'b01;

    // ------------------------------------------------------------
    // Command codes and phase lengths (in beats; DUMMY_DDR_CYC in sck cycles)
    // ------------------------------------------------------------
    localparam logic [7:0]  CODE_RDCFG2     = 8'h71;
    localparam logic [7:0]  CODE_RDCFG2_OPT = 8'h8e;
    localparam logic [7:0]  CODE_WRITE_ENABLE_CMD       = 8'h06;
    localparam logic [7:0]  CODE_WRITE_ENABLE_CMD_OPT   = 8'hf9;
    localparam logic [5:0]  LEN_SDR_CMD     = 6'd8;
    localparam logic [5:0]  LEN_SDR_ADDR    = 6'd32;
    localparam logic [5:0]  LEN_SDR_OPT     = 6'd32;
    localparam logic [5:0]  LEN_SDR_DATA    = 6'd8;
    localparam logic [5:0]  LEN_SDR_DUMMY   = 6'd0;
    localparam logic [5:0]  LEN_DDR_ADDR    = 6'd4;
    localparam logic [5:0]  LEN_DDR_OPT     = 6'd4;
    localparam logic [4:0]  DUMMY_DDR_CYC   = 5'd14;
    localparam logic [5:0]  LEN_DDR_DUMMY   = {DUMMY_DDR_CYC, 1'b0};
    localparam logic [5:0]  LEN_DDR_DATA    = 6'd2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic {
        SEL_RDCFG2,
        SEL_WRITE_ENABLE_CMD
    } mfc_cmd_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_ADDR,
        ST_OPT,
        ST_DUMMY,
        ST_DATA,
        ST_FINISH
    } mfc_state_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } mfc_apb_req_type;

    typedef struct packed {
        logic       sck;
        logic       cs_n;
        logic [7:0] io_out;
        logic [7:0] io_oe_n;
    } mfc_flash_out_type;

endpackage

// file: rtl/mfc_sync.sv
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/100ps
module mfc_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule // mfc_sync

// file: rtl/mfc_seq.sv
// Manual command sequencer for an octal serial flash, with APB register slave
// Operation
// RULE1: Write-enable command must be issued before any flash register write.
// RULE2: Flash sets its write enable latch on receiving code 06.
// RULE3: Single-line config-2 read sends code 71 then 32-bit SDR address.
// RULE4: Octal config-2 read sends code 71 on 8 lines; 8E optional, off.
// RULE5: Octal config-2 read drives its address on 8 lines, both edges.
// RULE6: Octal config-2 read inserts 14 dummy cycles before data.
// RULE7: Read data taken 8 bits per edge in octal, 1 bit SDR otherwise.
// RULE8: Single-line config-2 read has no dummy phase, count zero.
// RULE9: Single-line write enable is code 06 only, no further phases.
// RULE10: Octal write enable sends 06 on 8 lines; F9 optional; no address.
// RULE11: Option bytes leave byte 3 first; disabled and zero by default.
// RULE12: Idle lines 0-3 select level one; lines 0,2,3 float. Reset floats all four, line 1 included (IDLE_FLT_RST ff).
// RULE13: Chip select held low from first command bit to last data bit.
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/100ps
module mfc_seq (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       resetn,
    // APB slave
    input  wire mfc_pkg::mfc_apb_req_type   apb_req,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Flash pins
    input  wire logic [7:0]                 io_in,
    output mfc_pkg::mfc_flash_out_type      flash_out
);
    import mfc_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0]    io_sync;
    logic          ctrl_octal_reg;
    logic          ctrl_opt_en_reg;
    logic          ctrl_ocmd_en_reg;
    mfc_cmd_type   ctrl_cmd_reg;
    logic [31:0]   addr_reg;
    logic [31:0]   opt_reg;
    logic [7:0]    idle_lvl_reg;
    logic [7:0]    idle_flt_reg;
    logic [31:0]   rdata_reg;
    logic          wel_sent_reg;
    mfc_state_type state_reg;
    mfc_state_type state_next;
    logic [2:0]    beat_reg;
    logic [5:0]    unit_reg;
    logic [5:0]    phase_len;
    logic [31:0]   shf_reg;
    logic [31:0]   shf_next;
    mfc_cmd_type   cur_cmd_reg;
    logic          cur_octal_reg;
    logic          cur_opt_reg;
    logic          cur_ocmd_reg;
    logic          apb_write;
    logic          start_go;
    logic          busy;
    logic          phase_end;
    logic [31:0]   rd_mux;
    logic          rd_err;
    logic [7:0]    first_code;
    logic [7:0]    opt_code;

    // ------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------
    mfc_sync #(.W(8)) u_io_sync (
        .clk    (clk),
        .resetn (resetn),
        .d      (io_in),
        .q      (io_sync)
    );

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign apb_write = apb_req.psel & apb_req.penable & pready & apb_req.pwrite;
    assign busy      = (state_reg != ST_IDLE);
    assign start_go  = apb_write && (apb_req.paddr == REG_CTRL)
                       && apb_req.pwdata[CTRL_START] && !busy;

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b0;
        case (apb_req.paddr)
            REG_CTRL:  rd_mux = {27'h0, ctrl_ocmd_en_reg, ctrl_opt_en_reg, ctrl_octal_reg,
                                 ctrl_cmd_reg, 1'b0};
            REG_ADDR:  rd_mux = addr_reg;
            REG_STAT:  rd_mux = {30'h0, wel_sent_reg, busy};
            REG_RDATA: rd_mux = rdata_reg;
            REG_IDLE:  rd_mux = {16'h0, idle_flt_reg, idle_lvl_reg};
            REG_OPT:   rd_mux = opt_reg;
            default:   rd_err = 1'b1;
        endcase
    end

    // Ready one cycle after setup: every access takes exactly two cycles
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= apb_req.psel & ~apb_req.penable;
            prdata  <= (apb_req.psel & ~apb_req.penable & ~apb_req.pwrite) ? rd_mux : 32'h0;
            pslverr <= apb_req.psel & ~apb_req.penable & rd_err;
        end
    end

    // Configuration registers; held stable while a command runs
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl_cmd_reg     <= SEL_RDCFG2;
            ctrl_octal_reg   <= 1'b0;
            ctrl_opt_en_reg  <= 1'b0;
            ctrl_ocmd_en_reg <= 1'b0;
            addr_reg         <= 32'h0000_0000;
            opt_reg          <= OPT_RST;
            idle_lvl_reg     <= IDLE_LVL_RST;
            idle_flt_reg     <= IDLE_FLT_RST;
        end else if (apb_write && !busy) begin
            case (apb_req.paddr)
                REG_CTRL: begin
                    ctrl_cmd_reg     <= mfc_cmd_type'(apb_req.pwdata[CTRL_CMD_SEL]);
                    ctrl_octal_reg   <= apb_req.pwdata[CTRL_OCTAL];
                    ctrl_opt_en_reg  <= apb_req.pwdata[CTRL_OPT_EN];
                    ctrl_ocmd_en_reg <= apb_req.pwdata[CTRL_OCMD_EN];
                end
                REG_ADDR: addr_reg <= apb_req.pwdata;
                REG_IDLE: begin
                    idle_lvl_reg <= apb_req.pwdata[IDLE_LVL_LSB +: 8];
                    idle_flt_reg <= apb_req.pwdata[IDLE_FLT_LSB +: 8];
                end
                REG_OPT:  opt_reg <= apb_req.pwdata;
                default: begin
                end
            endcase
        end
    end

    // Write-enable sent flag: completion beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wel_sent_reg <= 1'b0;
        end else if (state_reg == ST_FINISH && cur_cmd_reg == SEL_WRITE_ENABLE_CMD) begin
            wel_sent_reg <= 1'b1; // RULE1
        end else if (apb_write && apb_req.paddr == REG_STAT
                     && apb_req.pwdata[STAT_WEL_SENT]) begin
            wel_sent_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Phase lengths and order
    // ------------------------------------------------------------
    assign first_code = (cur_cmd_reg == SEL_WRITE_ENABLE_CMD) ? CODE_WRITE_ENABLE_CMD : CODE_RDCFG2;
    assign opt_code   = (cur_cmd_reg == SEL_WRITE_ENABLE_CMD) ? CODE_WRITE_ENABLE_CMD_OPT : CODE_RDCFG2_OPT;
    assign phase_end  = (beat_reg == BEAT_LAST) && (unit_reg == phase_len - 6'd1);

    always_comb begin
        phase_len  = LEN_SDR_CMD;
        state_next = ST_FINISH;
        shf_next   = 32'h0000_0000;
        case (state_reg)
            ST_CMD: begin
                if (cur_octal_reg) begin
                    phase_len = cur_ocmd_reg ? 6'd2 : 6'd1; // RULE4 RULE10
                end
                if (cur_cmd_reg == SEL_WRITE_ENABLE_CMD) begin
                    state_next = ST_FINISH; // RULE9 RULE10
                end else begin
                    state_next = ST_ADDR; // RULE3
                    shf_next   = addr_reg;
                end
            end
            ST_ADDR: begin
                phase_len = cur_octal_reg ? LEN_DDR_ADDR : LEN_SDR_ADDR; // RULE5
                if (cur_opt_reg) begin
                    state_next = ST_OPT;
                    shf_next   = opt_reg; // RULE11
                end else if (cur_octal_reg) begin
                    state_next = ST_DUMMY; // RULE6
                end else begin
                    state_next = ST_DATA; // RULE8
                end
            end
            ST_OPT: begin
                phase_len  = cur_octal_reg ? LEN_DDR_OPT : LEN_SDR_OPT;
                state_next = (cur_octal_reg && LEN_DDR_DUMMY != 6'd0) ? ST_DUMMY : ST_DATA;
            end
            ST_DUMMY: begin
                phase_len  = cur_octal_reg ? LEN_DDR_DUMMY : LEN_SDR_DUMMY; // RULE6
                state_next = ST_DATA;
            end
            ST_DATA: begin
                phase_len  = cur_octal_reg ? LEN_DDR_DATA : LEN_SDR_DATA; // RULE7
                state_next = ST_FINISH;
            end
            default: begin
                phase_len  = LEN_SDR_CMD;
                state_next = ST_FINISH;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg     <= ST_IDLE;
            beat_reg      <= 3'd0;
            unit_reg      <= 6'd0;
            shf_reg       <= 32'h0000_0000;
            cur_cmd_reg   <= SEL_RDCFG2;
            cur_octal_reg <= 1'b0;
            cur_opt_reg   <= 1'b0;
            cur_ocmd_reg  <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start_go) begin
                        state_reg     <= ST_CMD;
                        beat_reg      <= 3'd0;
                        unit_reg      <= 6'd0;
                        cur_cmd_reg   <= mfc_cmd_type'(apb_req.pwdata[CTRL_CMD_SEL]);
                        cur_octal_reg <= apb_req.pwdata[CTRL_OCTAL];
                        cur_opt_reg   <= apb_req.pwdata[CTRL_OPT_EN]
                                         && !apb_req.pwdata[CTRL_CMD_SEL];
                        cur_ocmd_reg  <= apb_req.pwdata[CTRL_OCMD_EN];
                        // Command byte only; the optional byte replaces it after its first octal beat
                        shf_reg       <= {(apb_req.pwdata[CTRL_CMD_SEL] ? CODE_WRITE_ENABLE_CMD
                                           : CODE_RDCFG2), 24'h0};
                    end
                end
                ST_FINISH: begin
                    state_reg <= ST_IDLE;
                end
                default: begin
                    beat_reg <= beat_reg + 3'd1;
                    if (beat_reg == BEAT_LAST) begin
                        if (state_reg == ST_CMD && unit_reg == 6'd0 && cur_octal_reg) begin
                            shf_reg <= {opt_code, 24'h0};
                        end else if (cur_octal_reg) begin
                            shf_reg <= {shf_reg[23:0], 8'h00};
                        end else begin
                            shf_reg <= {shf_reg[30:0], 1'b0};
                        end
                        if (phase_end) begin
                            unit_reg  <= 6'd0;
                            state_reg <= state_next;
                            shf_reg   <= shf_next;
                        end else begin
                            unit_reg <= unit_reg + 6'd1;
                        end
                    end
                end
            endcase
        end
    end

    // Read data capture, one beat per byte (octal) or bit (single line)
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata_reg <= 32'h0000_0000;
        end else if (start_go) begin
            rdata_reg <= 32'h0000_0000;
        end else if (state_reg == ST_DATA && beat_reg == SAMPLE_AT) begin
            if (cur_octal_reg) begin
                rdata_reg <= {rdata_reg[23:0], io_sync}; // RULE7
            end else begin
                rdata_reg <= {rdata_reg[30:0], io_sync[1]}; // RULE7
            end
        end
    end

    // ------------------------------------------------------------
    // Flash pins
    // ------------------------------------------------------------
    // Lines 0-3 not carrying data follow the idle selections; line 1 must float
    // in single-line reads because the flash answers on it.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            flash_out.sck     <= 1'b0;
            flash_out.cs_n    <= 1'b1;
            flash_out.io_out  <= 8'hff;
            flash_out.io_oe_n <= 8'hff;
        end else begin
            flash_out.cs_n <= (state_reg == ST_IDLE) || (state_reg == ST_FINISH); // RULE13
            if (state_reg == ST_IDLE || state_reg == ST_FINISH) begin
                flash_out.sck <= 1'b0;
            end else if (beat_reg == EDGE_AT) begin
                flash_out.sck <= cur_octal_reg ? ~flash_out.sck : 1'b1; // RULE5
            end else if (beat_reg == 3'd0 && !cur_octal_reg) begin
                flash_out.sck <= 1'b0;
            end
            if (beat_reg == 3'd0 || state_reg == ST_IDLE) begin
                for (int n = 0; n < 4; n++) begin
                    if (idle_flt_reg[2*n +: 2] != SEL_FLOAT) begin
                        flash_out.io_out[n]  <= (idle_lvl_reg[2*n +: 2] == SEL_ONE); // RULE12
                        flash_out.io_oe_n[n] <= 1'b0;
                    end else begin
                        flash_out.io_out[n]  <= 1'b1;
                        flash_out.io_oe_n[n] <= 1'b1; // RULE12
                    end
                end
                // Upper lines only ever carry octal phases
                flash_out.io_out[7:4]  <= 4'hf;
                flash_out.io_oe_n[7:4] <= 4'hf;
                if (state_reg == ST_CMD || state_reg == ST_ADDR || state_reg == ST_OPT) begin
                    if (cur_octal_reg) begin
                        flash_out.io_out  <= shf_reg[31:24]; // RULE4 RULE5 RULE10
                        flash_out.io_oe_n <= 8'h00;
                    end else begin
                        flash_out.io_out[0]  <= shf_reg[31]; // RULE3 RULE9 RULE11
                        flash_out.io_oe_n[0] <= 1'b0;
                    end
                end
            end
        end
    end
endmodule // mfc_seq

// file: tb/mfc_seq_props.sv
// Checker: port-level properties of the manual flash command sequencer
`timescale 1ns/100ps
module mfc_seq_props (
    // Clock and reset
    input wire logic                       clk,
    input wire logic                       resetn,
    // APB
    input wire mfc_pkg::mfc_apb_req_type   apb_req,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    // Flash pins
    input wire logic [7:0]                 io_in,
    input wire mfc_pkg::mfc_flash_out_type flash_out
);
    import mfc_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // ------------------------------------------------------------
    // Sequences and properties
    // ------------------------------------------------------------
    sequence s_setup;
        apb_req.psel && !apb_req.penable;
    endsequence
    sequence s_open;
        $fell(flash_out.cs_n);
    endsequence
    property p_ready_next;
        s_setup |=> pready;
    endproperty
    property p_ready_cause;
        pready |-> $past(apb_req.psel && !apb_req.penable);
    endproperty
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    property p_rdata_quiet;
        !pready |-> prdata == 32'h0000_0000;
    endproperty
    // Only a settled idle is judged; the closing cycle may still release lines
    property p_idle_hiz;
        flash_out.cs_n && $past(flash_out.cs_n) |-> flash_out.io_oe_n == 8'hff;
    endproperty
    property p_sck_idle;
        flash_out.cs_n |-> !flash_out.sck;
    endproperty
    property p_first_beat;
        s_open |-> (!flash_out.cs_n && !flash_out.io_oe_n[0])[*8];
    endproperty
    property p_sck_frame;
        $changed(flash_out.sck) |-> !$past(flash_out.cs_n);
    endproperty
    property p_io_stands;
        $changed(flash_out.io_out) && !flash_out.cs_n |=> $stable(flash_out.io_out)[*7];
    endproperty
    a_ready_next: assert property (p_ready_next) else $error("pready missing after setup");
    a_ready_cause: assert property (p_ready_cause) else $error("pready without setup");
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    a_rdata_quiet: assert property (p_rdata_quiet) else $error("prdata not zero");
    a_idle_hiz: assert property (p_idle_hiz) else $error("data line driven in idle");
    a_sck_idle: assert property (p_sck_idle) else $error("sck high in idle");
    a_first_beat: assert property (p_first_beat) else $error("first beat cut short");
    a_sck_frame: assert property (p_sck_frame) else $error("sck moved outside frame");
    a_io_stands: assert property (p_io_stands) else $error("data changed within beat");
endmodule // mfc_seq_props

bind mfc_seq mfc_seq_props u_props (
    .clk(clk), .resetn(resetn), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .io_in(io_in), .flash_out(flash_out)
);

// file: tb/mfc_flash_model.sv
// Behavioural octal serial flash partner for the manual command sequencer
`timescale 1ns/100ps
module mfc_flash_model (
    // Clock and mode
    input  wire logic                       clk,
    input  wire logic                       octal,
    // Flash pins
    input  wire mfc_pkg::mfc_flash_out_type fo,
    output logic      [7:0]                 io_in,
    // Observed frame
    output logic      [71:0]                sh,
    output int                              nd,
    output int                              ne,
    output logic                            write_enable_latch
);
    import mfc_pkg::*;
    localparam logic [15:0] RD = 16'hc35a;
    logic [7:0] fb, fv, fen, lastv;
    logic       sck_q, cs_q;
    int         nr;
    initial begin
        {sh, fb, fv, fen, lastv, write_enable_latch, sck_q} = '0;
        cs_q = 1'b1;
        nd = 0;
        ne = 0;
        nr = 0;
    end
    // Released lines flip every cycle so a stale value never looks valid
    assign io_in = (~fo.io_oe_n & fo.io_out) | (fo.io_oe_n & fen & fv)
                 | (fo.io_oe_n & ~fen & ~lastv);
    always @(posedge clk) begin
        lastv <= io_in;
        sck_q <= fo.sck;
        cs_q <= fo.cs_n;
        if (!fo.cs_n && cs_q) begin
            {sh, fb} <= '0;
            nd <= 0;
            ne <= 0;
            nr <= 0;
        end
        if (fo.cs_n) fen <= 8'h00;
        if (fo.cs_n && !cs_q && fb == 8'h06) write_enable_latch <= 1'b1;
        if (!fo.cs_n && fo.sck != sck_q && (octal || fo.sck)) begin
            ne <= ne + 1;
            if (!octal && !fo.io_oe_n[0]) begin
                sh <= {sh[70:0], fo.io_out[0]};
                nd <= nd + 1;
                if (nd == 7) fb <= {sh[6:0], fo.io_out[0]};
            end
            if (octal && fo.io_oe_n == 8'h00) begin
                sh <= {sh[63:0], fo.io_out};
                nd <= nd + 1;
                if (nd == 0) fb <= fo.io_out;
            end
            // Octal answer set one edge ahead so it stands at the sample point
            if (octal && fo.io_oe_n == 8'hff) begin
                nr <= nr + 1;
                if (nr == 27) fen <= 8'hff;
                if (nr == 27) fv <= RD[15:8];
                if (nr == 28) fv <= RD[7:0];
            end
        end
        if (!octal && !fo.cs_n && sck_q && !fo.sck && fo.io_oe_n[0] && nr < 8) begin
            fen <= 8'h02;
            fv <= {6'h00, RD[15 - nr], 1'b0};
            nr <= nr + 1;
        end
    end
endmodule // mfc_flash_model

// file: tb/tb_top.sv
// Testbench: register and flash-pin scenarios for the manual command sequencer
`timescale 1ns/100ps
module tb_top;
    import mfc_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam logic [31:0] A = 32'h1234_5678;
    logic              clk, resetn, pready, pslverr, rerr, oct, write_enable_latch;
    logic [31:0]       prdata, rdat;
    logic [7:0]        io_in;
    logic [71:0]       sh;
    mfc_apb_req_type   req;
    mfc_flash_out_type fo;
    int                nd, ne, errors, n_checks;
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    mfc_seq dut (.clk(clk), .resetn(resetn), .apb_req(req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .io_in(io_in), .flash_out(fo));
    mfc_flash_model u_flash (.clk(clk), .octal(oct), .fo(fo), .io_in(io_in),
        .sh(sh), .nd(nd), .ne(ne), .write_enable_latch(write_enable_latch));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            errors++;
            $display("Error at %0t: no pready", $time);
        end
        rdat = prdata;
        rerr = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(72'(rdat), 72'(e));
    endtask
    // Start, try a refused address write while busy, then poll until idle
    task automatic run(input logic [31:0] c);
        int n;
        n = 0;
        oct <= c[CTRL_OCTAL];
        xfer(1'b1, REG_CTRL, c);
        xfer(1'b1, REG_ADDR, 32'hffff_ffff);
        do begin
            xfer(1'b0, REG_STAT, 32'h0);
            n++;
        end while (rdat[STAT_BUSY] !== 1'b0 && n < 400);
        if (rdat[STAT_BUSY] !== 1'b0) begin
            errors++;
            $display("Error at %0t: command never finished", $time);
        end
    endtask
    task automatic close_out;
        $display("Checks %0d, errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        #500_000;
        errors++;
        close_out;
    end
    initial begin
        resetn = 1'b0;
        req = '0;
        oct = 1'b0;
        errors = 0;
        n_checks = 0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        chk(72'(fo.io_oe_n), 72'hff);
        rdchk(REG_IDLE, 32'h0000_ff55);
        rdchk(REG_OPT, 32'h0);
        rdchk(REG_STAT, 32'h0);
        xfer(1'b0, 8'h18, 32'h0);
        chk(72'(rerr), 72'h1);
        xfer(1'b1, REG_ADDR, A);
        chk(72'(write_enable_latch), 72'h0);
        run(32'h3);
        chk(sh, 72'h06);
        chk(72'(ne), 72'd8);
        chk(72'(write_enable_latch), 72'h1);
        rdchk(REG_STAT, 32'h2);
        xfer(1'b1, REG_STAT, 32'h2);
        rdchk(REG_STAT, 32'h0);
        run(32'h7);
        chk(sh, 72'h06);
        chk(72'(nd), 72'd1);
        run(32'h17);
        chk(sh, 72'h06f9);
        run(32'h1);
        chk(sh, {32'h0, 8'h71, A});
        chk(72'(ne), 72'd48);
        rdchk(REG_RDATA, 32'h0000_00c3);
        rdchk(REG_ADDR, A);
        xfer(1'b1, REG_OPT, 32'h1122_3344);
        run(32'h9);
        chk(sh, {8'h71, A, 32'h1122_3344});
        chk(72'(ne), 72'd80);
        run(32'h5);
        chk(sh, {32'h0, 8'h71, A});
        chk(72'(ne), 72'd35);
        rdchk(REG_RDATA, 32'h0000_c35a);
        run(32'hd);
        chk(sh, {8'h71, A, 32'h1122_3344});
        chk(72'(ne), 72'd39);
        run(32'h15);
        chk(sh, {24'h0, 8'h71, 8'h8e, A});
        chk(72'(ne), 72'd36);
        rdchk(REG_RDATA, 32'h0000_c35a);
        close_out;
    end
endmodule // tb_top
